// ==== shared/sasc_defs.svh ====
`ifndef SASC_DEFS_SVH
`define SASC_DEFS_SVH
// register addresses (fieldbus object addresses)
`define SASC_ADDR_ALARM      16'h1f00
`define SASC_ADDR_RESTART    16'h2f00
`define SASC_ADDR_QS_DEC     16'h3300
`define SASC_ADDR_QS_SEL     16'h3400
`define SASC_ADDR_SHDN_SEL   16'h3410
`define SASC_ADDR_DIS_SEL    16'h3420
`define SASC_ADDR_PAUSE_SEL  16'h3430
`define SASC_ADDR_ALM_SEL    16'h3440
`define SASC_ADDR_PROF_DEC   16'h4c00
`define SASC_ADDR_MLIB_SEL   16'h3041
`define SASC_ADDR_ENC_RES    16'h6410
`define SASC_ADDR_CTRL_WORD  16'h6040
// command codes and field positions
`define SASC_CW_QUICK_STOP   16'h000b
`define SASC_CW_PAUSE_BIT    8
`define SASC_CMD_BOOT        16'h55aa
`define SASC_CMD_RESTART     16'haa55
`define SASC_RES_4000        16'h0fa0
`define SASC_RES_8000        16'h1f40
`define SASC_RES_10000       16'h2710
// reset values
`define SASC_RST_SEL         16'h0000
`define SASC_RST_DEC         32'h0000_0000
`define SASC_RST_MLIB        8'h00
`define SASC_RST_RES         16'h0000
`endif

// ==== shared/sasc_pkg.sv ====
package sasc_pkg;
  typedef enum logic [2:0] {
    SASC_STOP_NONE   = 3'b000,
    SASC_STOP_COAST  = 3'b001,
    SASC_STOP_PROF   = 3'b010,
    SASC_STOP_QUICK  = 3'b011,
    SASC_STOP_HOLD   = 3'b100
  } sasc_stop_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [31:0] wdata;
  } sasc_req_t;
  typedef struct packed {
    sasc_stop_t  kind;
    logic        in_qs_state;
    logic [31:0] decel;
  } sasc_stop_cmd_t;
endpackage

// ==== logic/sasc_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sasc_defs.svh"
// Notes on behaviour
// R01: 16-bit read-only alarm word shows live faults; bit 0 internal error.
// R02: bits 1..3 flag ABZ wiring, UVW wiring and encoder counting faults.
// R03: bits 4..7 flag overtemperature, overvoltage, undervoltage, overcurrent.
// R04: bits 8..10 flag braking resistor, following error, logic undervoltage.
// R05: bits 11..15 flag I2t, pulse frequency, motor temp, excitation, memory.
// R06: limit, emergency stop or control word 0x000B trigger quick stop.
// R07: quick-stop selector 0 coast, 1 profile, 2 quick; 5,6 then hold.
// R08: shutdown and disable selectors choose 0 coast, 1 profile, 2 quick.
// R09: control word bit 8 pauses, stays enabled; 1 current, 2 quick decel.
// R10: any alarm stops per alarm selector: 0 immediate, 1 ramp, 2 quick.
// R11: profile deceleration ramps modes 1 and 3; separate quick-stop value.
// R12: library selector 0 reads model from encoder; 1 uses manual model.
// R13: encoder emulation accepts 4000, 8000, 10000; zero disables emulation.
// R14: 0x55AA enters bootloader, 0xAA55 restarts; other codes do nothing.
module sasc_ctrl
  import sasc_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        REQ_VALID,
  input  wire logic        REQ_WRITE,
  input  wire logic [15:0] REQ_ADDR,
  input  wire logic [31:0] REQ_WDATA,
  input  wire logic [15:0] FAULT_IN,
  input  wire logic        LIMIT_TRIP,
  input  wire logic        ESTOP_TRIP,
  input  wire logic        DRIVE_ENABLE,
  input  wire logic        DRIVE_DISABLE,
  input  wire logic [7:0]  OP_MODE,
  output logic             RSP_VALID,
  output logic [31:0]      RSP_RDATA,
  output logic             RSP_ERR,
  output logic [2:0]       STOP_KIND,
  output logic             STOP_HOLD_QS,
  output logic [31:0]      STOP_DECEL,
  output logic [31:0]      RAMP_DECEL,
  output logic             PAUSE_ACTIVE,
  output logic             AUTO_MOTOR_LIB,
  output logic [15:0]      ENC_EMU_RES,
  output logic             ENC_EMU_EN,
  output logic             BOOT_PULSE,
  output logic             RESTART_PULSE
);
  sasc_req_t      req;
  sasc_stop_cmd_t cmd_nxt;
  logic [15:0] alarm_r;
  logic [15:0] restart_r;
  logic [31:0] qs_dec_r;
  logic [31:0] prof_dec_r;
  logic [15:0] qs_sel_r;
  logic [15:0] shdn_sel_r;
  logic [15:0] dis_sel_r;
  logic [15:0] pause_sel_r;
  logic [15:0] alm_sel_r;
  logic [7:0]  mlib_r;
  logic [15:0] res_r;
  logic [15:0] ctrl_r;
  logic        qs_latched_r;
  logic        wr;
  logic        res_ok;
  logic [31:0] rdata_nxt;
  logic        rerr_nxt;

  assign req    = '{valid: REQ_VALID, write: REQ_WRITE, addr: REQ_ADDR, wdata: REQ_WDATA};
  assign wr     = req.valid && req.write;
  assign res_ok = (req.wdata[15:0] == `SASC_RST_RES) || (req.wdata[15:0] == `SASC_RES_4000) ||
                  (req.wdata[15:0] == `SASC_RES_8000) || (req.wdata[15:0] == `SASC_RES_10000); // R13

  // live fault bits are sampled every cycle; one bit per source
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_alarm
      always_ff @(posedge SYS_CLK) begin
        if (RST) begin
          alarm_r[g] <= 1'b0;
        end else begin
          alarm_r[g] <= FAULT_IN[g]; // R01 R02 R03 R04 R05
        end
      end
    end
  endgenerate

  // decelerations are written as whole 32-bit words; no half-word updates
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      qs_dec_r   <= `SASC_RST_DEC;
      prof_dec_r <= `SASC_RST_DEC;
    end else if (wr) begin
      case (req.addr)
        `SASC_ADDR_QS_DEC:   qs_dec_r   <= req.wdata; // R11
        `SASC_ADDR_PROF_DEC: prof_dec_r <= req.wdata; // R11
        default: begin
        end
      endcase
    end
  end

  // unlisted selector codes are still stored; the decode treats them as a profile stop
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      qs_sel_r    <= `SASC_RST_SEL;
      shdn_sel_r  <= `SASC_RST_SEL;
      dis_sel_r   <= `SASC_RST_SEL;
      pause_sel_r <= `SASC_RST_SEL;
      alm_sel_r   <= `SASC_RST_SEL;
    end else if (wr) begin
      case (req.addr)
        `SASC_ADDR_QS_SEL:    qs_sel_r    <= req.wdata[15:0]; // R07
        `SASC_ADDR_SHDN_SEL:  shdn_sel_r  <= req.wdata[15:0]; // R08
        `SASC_ADDR_DIS_SEL:   dis_sel_r   <= req.wdata[15:0]; // R08
        `SASC_ADDR_PAUSE_SEL: pause_sel_r <= req.wdata[15:0]; // R09
        `SASC_ADDR_ALM_SEL:   alm_sel_r   <= req.wdata[15:0]; // R10
        default: begin
        end
      endcase
    end
  end

  // command-like words; restart word keeps whatever was written for read-back
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      mlib_r    <= `SASC_RST_MLIB;
      restart_r <= 16'h0000;
      ctrl_r    <= 16'h0000;
    end else if (wr) begin
      case (req.addr)
        `SASC_ADDR_MLIB_SEL:  mlib_r    <= req.wdata[7:0]; // R12
        `SASC_ADDR_RESTART:   restart_r <= req.wdata[15:0];
        `SASC_ADDR_CTRL_WORD: ctrl_r    <= req.wdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // out-of-range resolutions are refused so emulation never runs at a bogus rate
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      res_r <= `SASC_RST_RES;
    end else if (wr && req.addr == `SASC_ADDR_ENC_RES && res_ok) begin
      res_r <= req.wdata[15:0]; // R13
    end
  end

  // read mux kept combinational so the answer flops see one settled value
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    rerr_nxt  = 1'b0;
    if (req.valid) begin
      case (req.addr)
        `SASC_ADDR_ALARM: begin
          rdata_nxt = {16'h0000, alarm_r};
          rerr_nxt  = req.write; // R01
        end
        `SASC_ADDR_RESTART: begin
          rdata_nxt = {16'h0000, restart_r};
        end
        `SASC_ADDR_QS_DEC: begin
          rdata_nxt = qs_dec_r;
        end
        `SASC_ADDR_PROF_DEC: begin
          rdata_nxt = prof_dec_r;
        end
        `SASC_ADDR_QS_SEL: begin
          rdata_nxt = {16'h0000, qs_sel_r};
        end
        `SASC_ADDR_SHDN_SEL: begin
          rdata_nxt = {16'h0000, shdn_sel_r};
        end
        `SASC_ADDR_DIS_SEL: begin
          rdata_nxt = {16'h0000, dis_sel_r};
        end
        `SASC_ADDR_PAUSE_SEL: begin
          rdata_nxt = {16'h0000, pause_sel_r};
        end
        `SASC_ADDR_ALM_SEL: begin
          rdata_nxt = {16'h0000, alm_sel_r};
        end
        `SASC_ADDR_MLIB_SEL: begin
          rdata_nxt = {24'h000000, mlib_r};
        end
        `SASC_ADDR_CTRL_WORD: begin
          rdata_nxt = {16'h0000, ctrl_r};
        end
        `SASC_ADDR_ENC_RES: begin
          rdata_nxt = {16'h0000, res_r};
          rerr_nxt  = req.write && !res_ok; // R13
        end
        default: begin
          // unmapped objects answer with an error and zero data
          rerr_nxt = 1'b1;
        end
      endcase
    end
  end

  // register read / write answer, one cycle after the request
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      RSP_VALID <= 1'b0;
      RSP_RDATA <= 32'h0000_0000;
      RSP_ERR   <= 1'b0;
    end else begin
      RSP_VALID <= req.valid;
      RSP_RDATA <= rdata_nxt;
      RSP_ERR   <= rerr_nxt;
    end
  end

  // restart word acts once per write of an exact code
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      BOOT_PULSE    <= 1'b0;
      RESTART_PULSE <= 1'b0;
    end else begin
      BOOT_PULSE    <= wr && req.addr == `SASC_ADDR_RESTART && req.wdata[15:0] == `SASC_CMD_BOOT;    // R14
      RESTART_PULSE <= wr && req.addr == `SASC_ADDR_RESTART && req.wdata[15:0] == `SASC_CMD_RESTART; // R14
    end
  end

  function automatic sasc_stop_t sel3(input logic [15:0] s);
    case (s)
      16'h0000: sel3 = SASC_STOP_COAST;
      16'h0001: sel3 = SASC_STOP_PROF;
      16'h0002: sel3 = SASC_STOP_QUICK;
      default:  sel3 = SASC_STOP_PROF;
    endcase
  endfunction

  // priority: alarm, quick stop, disable, shutdown, pause
  always_comb begin
    cmd_nxt = '{kind: SASC_STOP_NONE, in_qs_state: 1'b0, decel: prof_dec_r};
    if (|alarm_r) begin
      cmd_nxt.kind = sel3(alm_sel_r); // R10
    end else if (LIMIT_TRIP || ESTOP_TRIP || ctrl_r == `SASC_CW_QUICK_STOP || qs_latched_r) begin // R06
      case (qs_sel_r)
        16'h0000: cmd_nxt.kind = SASC_STOP_COAST; // R07
        16'h0001: cmd_nxt.kind = SASC_STOP_PROF;
        16'h0002: cmd_nxt.kind = SASC_STOP_QUICK;
        16'h0005: begin
          cmd_nxt.kind        = SASC_STOP_PROF;
          cmd_nxt.in_qs_state = 1'b1;
        end
        16'h0006: begin
          cmd_nxt.kind        = SASC_STOP_QUICK;
          cmd_nxt.in_qs_state = 1'b1;
        end
        default: cmd_nxt.kind = SASC_STOP_PROF;
      endcase
    end else if (DRIVE_DISABLE) begin
      cmd_nxt.kind = sel3(dis_sel_r); // R08
    end else if (!DRIVE_ENABLE) begin
      cmd_nxt.kind = sel3(shdn_sel_r); // R08
    end else if (ctrl_r[`SASC_CW_PAUSE_BIT]) begin
      cmd_nxt.kind = (pause_sel_r == 16'h0002) ? SASC_STOP_QUICK : SASC_STOP_PROF; // R09
    end
    if (cmd_nxt.kind == SASC_STOP_QUICK) begin
      cmd_nxt.decel = qs_dec_r; // R11
    end
  end

  // quick-stop state persists for selectors 5 and 6 until the control word is written with any value but 0x000B
  // clear wins here: the latch feeds its own set term, so set-wins could never release it
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      qs_latched_r <= 1'b0;
    end else if (wr && req.addr == `SASC_ADDR_CTRL_WORD && req.wdata[15:0] != `SASC_CW_QUICK_STOP) begin
      qs_latched_r <= 1'b0;
    end else if (cmd_nxt.in_qs_state) begin
      qs_latched_r <= 1'b1; // R07
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      STOP_KIND    <= SASC_STOP_NONE;
      STOP_HOLD_QS <= 1'b0;
      STOP_DECEL   <= `SASC_RST_DEC;
      RAMP_DECEL   <= `SASC_RST_DEC;
      PAUSE_ACTIVE <= 1'b0;
    end else begin
      STOP_KIND    <= cmd_nxt.kind;
      STOP_HOLD_QS <= cmd_nxt.in_qs_state;
      STOP_DECEL   <= cmd_nxt.decel;
      RAMP_DECEL   <= (OP_MODE == 8'h01 || OP_MODE == 8'h03) ? prof_dec_r : `SASC_RST_DEC; // R11
      PAUSE_ACTIVE <= ctrl_r[`SASC_CW_PAUSE_BIT] && DRIVE_ENABLE; // R09
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      AUTO_MOTOR_LIB <= 1'b1;
      ENC_EMU_RES    <= `SASC_RST_RES;
      ENC_EMU_EN     <= 1'b0;
    end else begin
      AUTO_MOTOR_LIB <= (mlib_r == 8'h00); // R12
      ENC_EMU_RES    <= res_r;
      ENC_EMU_EN     <= (res_r != `SASC_RST_RES); // R13
    end
  end
endmodule
`default_nettype wire

// ==== test/sasc_ctrl_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module sasc_ctrl_checker (
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        REQ_VALID,
  input wire logic        REQ_WRITE,
  input wire logic [15:0] REQ_ADDR,
  input wire logic [31:0] REQ_WDATA,
  input wire logic [15:0] FAULT_IN,
  input wire logic        LIMIT_TRIP,
  input wire logic        DRIVE_ENABLE,
  input wire logic [7:0]  OP_MODE,
  input wire logic        RSP_VALID,
  input wire logic        RSP_ERR,
  input wire logic [2:0]  STOP_KIND,
  input wire logic [31:0] RAMP_DECEL,
  input wire logic        PAUSE_ACTIVE,
  input wire logic [15:0] ENC_EMU_RES,
  input wire logic        ENC_EMU_EN,
  input wire logic        BOOT_PULSE,
  input wire logic        RESTART_PULSE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence s_wr(logic [15:0] a, logic [15:0] d);
    REQ_VALID && REQ_WRITE && REQ_ADDR == a && REQ_WDATA[15:0] == d;
  endsequence
  sequence s_alarm_wr;
    REQ_VALID && REQ_WRITE && REQ_ADDR == 16'h1f00;
  endsequence
  AST_BOOT: assert property (s_wr(16'h2f00, 16'h55aa) |=> BOOT_PULSE && !RESTART_PULSE)
    else $error("boot pulse wrong");
  AST_RESTART: assert property (s_wr(16'h2f00, 16'haa55) |=> RESTART_PULSE && !BOOT_PULSE)
    else $error("restart pulse wrong");
  AST_ALARM_RO: assert property (s_alarm_wr |=> RSP_VALID && RSP_ERR)
    else $error("alarm word write not refused");
  AST_ALM_STOP: assert property ((FAULT_IN != 16'h0)[*3] |-> STOP_KIND != 3'h0)
    else $error("no stop on alarm");
  AST_QS_TRIP: assert property ((LIMIT_TRIP && FAULT_IN == 16'h0)[*3] |-> STOP_KIND != 3'h0)
    else $error("no stop on limit trip");
  AST_RAMP: assert property ((OP_MODE != 8'h01 && OP_MODE != 8'h03)[*2] |-> RAMP_DECEL == 32'h0)
    else $error("ramp outside modes 1 and 3");
  AST_ENC_EN: assert property (ENC_EMU_EN == (ENC_EMU_RES != 16'h0))
    else $error("emulation enable mismatch");
  AST_PAUSE: assert property (PAUSE_ACTIVE |-> $past(DRIVE_ENABLE))
    else $error("pause while not enabled");
endmodule
bind sasc_ctrl sasc_ctrl_checker u_sasc_ctrl_checker (.SYS_CLK, .RST, .REQ_VALID, .REQ_WRITE, .REQ_ADDR,
  .REQ_WDATA, .FAULT_IN, .LIMIT_TRIP, .DRIVE_ENABLE, .OP_MODE, .RSP_VALID, .RSP_ERR, .STOP_KIND,
  .RAMP_DECEL, .PAUSE_ACTIVE, .ENC_EMU_RES, .ENC_EMU_EN, .BOOT_PULSE, .RESTART_PULSE);
`default_nettype wire

// ==== test/sasc_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module sasc_master
  import sasc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rsp_valid,
  input  wire logic [31:0] rsp_rdata,
  input  wire logic        rsp_err,
  output var  sasc_req_t   req
);
  initial req = '{1'b0, 1'b1, 16'hffff, 32'h0};
  // idle bus shows the inverse of the last request, so stale fields never look current
  task automatic access(input logic w, input logic [15:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
    @(posedge clk);
    #1 req = '{1'b1, w, a, d};
    @(posedge clk);
    #1 req = '{1'b0, ~w, ~a, ~d};
    for (int k = 0; k < 3 && rsp_valid !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    q = rsp_rdata;
    e = rsp_err;
  endtask
endmodule
`default_nettype wire

// ==== test/sasc_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sasc_defs.svh"
module sasc_ctrl_tb;
  import sasc_pkg::*;
  logic        clk, rst, lim, est, den, dis, rv, re, hq, pa, al, ee, bp, rp, er;
  logic [2:0]  sk;
  logic [7:0]  opm;
  logic [15:0] flt, res;
  logic [31:0] rdat, sd, rmp, rd, qd, pd;
  sasc_req_t   req;
  int          n_fail, checks, cyc;
  int unsigned mdl [int];
  logic [31:0] ev [5] = '{32'h0fa0, 32'h1f40, 32'h04d2, 32'h2710, 32'h0};
  logic [31:0] cv [3] = '{32'h55aa, 32'haa55, 32'h5a5a};
  int          qv [5] = '{0, 1, 2, 5, 6};
  logic [15:0] ra [7] = '{`SASC_ADDR_QS_SEL, `SASC_ADDR_SHDN_SEL, `SASC_ADDR_DIS_SEL, `SASC_ADDR_PAUSE_SEL,
                          `SASC_ADDR_ALM_SEL, `SASC_ADDR_QS_DEC, `SASC_ADDR_PROF_DEC};
  sasc_ctrl u_sasc_ctrl (.SYS_CLK(clk), .RST(rst), .REQ_VALID(req.valid), .REQ_WRITE(req.write),
    .REQ_ADDR(req.addr), .REQ_WDATA(req.wdata), .FAULT_IN(flt), .LIMIT_TRIP(lim), .ESTOP_TRIP(est),
    .DRIVE_ENABLE(den), .DRIVE_DISABLE(dis), .OP_MODE(opm), .RSP_VALID(rv), .RSP_RDATA(rdat), .RSP_ERR(re),
    .STOP_KIND(sk), .STOP_HOLD_QS(hq), .STOP_DECEL(sd), .RAMP_DECEL(rmp), .PAUSE_ACTIVE(pa),
    .AUTO_MOTOR_LIB(al), .ENC_EMU_RES(res), .ENC_EMU_EN(ee), .BOOT_PULSE(bp), .RESTART_PULSE(rp));
  sasc_master u_sasc_master (.clk(clk), .rsp_valid(rv), .rsp_rdata(rdat), .rsp_err(re), .req(req));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [31:0] d, logic e);
    u_sasc_master.access(1'b1, a, d, rd, er);
    cmp("wr_rsp_valid", 32'h1, {31'h0, rv});
    cmp("wr_err", {31'h0, e}, {31'h0, er});
  endtask
  task automatic rdc(logic [15:0] a, logic [31:0] exp, logic e);
    u_sasc_master.access(1'b0, a, 32'h0, rd, er);
    cmp("rd_rsp_valid", 32'h1, {31'h0, rv});
    cmp("rd_err", {31'h0, e}, {31'h0, er});
    cmp("rdata", exp, rd);
  endtask
  task automatic stop_chk(int s);
    logic [2:0] k;
    k = (s == 0) ? 3'h1 : (s == 1 || s == 5) ? 3'h2 : 3'h3;
    repeat (3) @(negedge clk);
    cmp("stop_kind", {29'h0, k}, {29'h0, sk});
    if (k != 3'h1) cmp("stop_decel", (k == 3'h2) ? pd : qd, sd);
  endtask
  initial begin
    void'($urandom(39503));
    {rst, lim, est, den, dis, opm, flt} = {4'b1001, 1'b0, 8'h01, 16'h0000};
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    cmp("auto_lib", 32'h1, {31'h0, al});
    qd = $urandom;
    pd = $urandom;
    wr(`SASC_ADDR_QS_DEC, qd, 1'b0);
    wr(`SASC_ADDR_PROF_DEC, pd, 1'b0);
    for (int m = 0; m < 4; m++) begin
      @(posedge clk) #1 opm = m[7:0];
      repeat (2) @(negedge clk);
      cmp("ramp", (m == 1 || m == 3) ? pd : 32'h0, rmp);
    end
    for (int v = 1; v >= 0; v--) begin
      wr(`SASC_ADDR_MLIB_SEL, v, 1'b0);
      repeat (2) @(negedge clk);
      cmp("auto_lib", {31'h0, v == 0}, {31'h0, al});
    end
    foreach (ev[i]) begin
      wr(`SASC_ADDR_ENC_RES, ev[i], ev[i] == 32'h04d2);
      if (ev[i] != 32'h04d2) mdl[`SASC_ADDR_ENC_RES] = ev[i];
      repeat (2) @(negedge clk);
      cmp("enc_res", mdl[`SASC_ADDR_ENC_RES], {16'h0, res});
      cmp("enc_en", {31'h0, mdl[`SASC_ADDR_ENC_RES] != 0}, {31'h0, ee});
    end
    foreach (cv[i]) begin
      wr(`SASC_ADDR_RESTART, cv[i], 1'b0);
      cmp("boot", {31'h0, cv[i] == 32'h55aa}, {31'h0, bp});
      cmp("restart", {31'h0, cv[i] == 32'haa55}, {31'h0, rp});
    end
    rdc(`SASC_ADDR_RESTART, 32'h5a5a, 1'b0);
    wr(`SASC_ADDR_ALARM, 32'hffff, 1'b1);
    rdc(16'h3450, 32'h0, 1'b1);
    for (int i = 0; i < 16; i++) begin
      wr(`SASC_ADDR_ALM_SEL, i % 3, 1'b0);
      flt = 16'h1 << i;
      rdc(`SASC_ADDR_ALARM, 32'h1 << i, 1'b0);
      stop_chk(i % 3);
    end
    flt = 16'h0000;
    foreach (qv[i]) begin
      wr(`SASC_ADDR_QS_SEL, qv[i], 1'b0);
      if (i % 3 == 2) wr(`SASC_ADDR_CTRL_WORD, 32'h000b, 1'b0);
      else {lim, est} = (i % 3 == 0) ? 2'b10 : 2'b01;
      stop_chk(qv[i]);
      cmp("hold_qs", {31'h0, qv[i] > 4}, {31'h0, hq});
      @(posedge clk) #1 {lim, est} = 2'b00;
      wr(`SASC_ADDR_CTRL_WORD, 32'h0, 1'b0);
    end
    for (int s = 0; s < 3; s++) begin
      wr(`SASC_ADDR_SHDN_SEL, s, 1'b0);
      wr(`SASC_ADDR_DIS_SEL, 2 - s, 1'b0);
      den = 1'b0;
      stop_chk(s);
      @(posedge clk) #1 dis = 1'b1;
      stop_chk(2 - s);
      @(posedge clk) #1 {den, dis} = 2'b10;
    end
    for (int s = 1; s < 3; s++) begin
      wr(`SASC_ADDR_PAUSE_SEL, s, 1'b0);
      wr(`SASC_ADDR_CTRL_WORD, 32'h0100, 1'b0);
      stop_chk(s);
      cmp("pause", 32'h1, {31'h0, pa});
    end
    wr(`SASC_ADDR_CTRL_WORD, 32'h0, 1'b0);
    foreach (ra[i]) begin
      mdl[ra[i]] = $urandom & ((i > 4) ? 32'hffffffff : 32'hffff);
      wr(ra[i], mdl[ra[i]], 1'b0);
    end
    foreach (ra[i]) rdc(ra[i], mdl[ra[i]], 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
